// ==== include/clock_bank_pkg.sv ====
// constants, register layouts and bus codes for the global clock, reset and status bank
package clock_bank_pkg;

   // ==========================================================
   // clocking
   localparam int unsigned hclk_khz   = 100000;
   localparam int unsigned nco_width  = 32;
   localparam int unsigned e1_ref_khz = 2048;
   localparam int unsigned t1_ref_khz = 1544;

   // ==========================================================
   // register indices (byte address is index shifted by word_shift)
   localparam int unsigned word_shift       = 2;
   localparam logic [7:0]  idx_bp_reference = 8'hF3;
   localparam logic [7:0]  idx_clock_routing = 8'hF4;
   localparam logic [7:0]  idx_group_reset  = 8'hF6;
   localparam logic [7:0]  idx_device_ident = 8'hF8;
   localparam logic [7:0]  idx_framer_irq   = 8'hF9;
   localparam logic [7:0]  idx_tester_irq   = 8'hFA;

   // ==========================================================
   // reset values
   localparam logic [7:0] bp_reference_reset = 8'h00;
   localparam logic [7:0] clock_routing_reset = 8'h00;
   localparam logic [7:0] group_reset_reset  = 8'h00;
   localparam logic [3:0] irq_summary_reset  = 4'h0;
   localparam logic [31:0] rdata_reset       = 32'h00000000;

   // ==========================================================
   // backplane reference source codes
   localparam logic [3:0] src_rx_ch1  = 4'h0;
   localparam logic [3:0] src_rx_ch4  = 4'h3;
   localparam logic [3:0] src_master  = 4'h8;
   localparam logic [3:0] src_ext_pin = 4'h9;

   // ==========================================================
   // ahb-lite codes
   localparam logic [1:0] htrans_nonseq = 2'h2;
   localparam logic [1:0] htrans_seq    = 2'h3;
   localparam logic       hresp_okay    = 1'h0;

   // ==========================================================
   // register layouts
   typedef struct packed {
      logic [3:0] bp_ref_source_sel;
      logic       bp_ref_freq_flag;
      logic [2:0] spare;
   } bp_reference_t;

   typedef struct packed {
      logic       spare;
      logic       rx_sys_clock_source;
      logic       tx_sys_clock_source;
      logic       tx_line_clock_source;
      logic [3:0] clock_out_freq_sel;
   } clock_routing_t;

   typedef struct packed {
      logic [3:0] spare;
      logic       hdlc_big_group_reset;
      logic       line_if_group_reset;
      logic       bit_tester_group_reset;
      logic       framer_group_reset;
   } group_reset_t;

   typedef struct packed {
      logic       write;
      logic [7:0] index;
   } bus_req_t;

   // ==========================================================
   // clock-out frequency table in khz, indexed by clock_out_freq_sel
   localparam int unsigned clock_out_khz [16] = '{
      2048, 4096, 8192, 16384,
      1544, 3088, 6176, 12352,
      1536, 3072, 6144, 12288,
      32, 64, 128, 256};

   // accumulator step that makes the accumulator msb run at khz
   function automatic logic [31:0] nco_step(input int unsigned khz);
      logic [63:0] wide;
      wide = (64'(khz) << nco_width) / 64'(hclk_khz);
      return wide[31:0];
   endfunction

endpackage

// ==== design/nco_clock_gen.sv ====
// phase accumulator clock synthesiser running on hclk
`timescale 1ns/1ns
`default_nettype none
module nco_clock_gen
   import clock_bank_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic [31:0] step,
   output logic             clock_level
);

   // ==========================================================
   // accumulator
   // jitter is one hclk period, the price of needing no pll
   logic [31:0] acc;
   logic [31:0] next_acc;

   always_comb
   begin
      next_acc = acc + step;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         acc         <= 32'h00000000;
         clock_level <= 1'h0;
      end
      else
      begin
         acc         <= next_acc;
         clock_level <= next_acc[31];
      end
   end

endmodule // nco_clock_gen
`default_nettype wire

// ==== design/global_clock_reset_status_bank.sv ====
// global clock routing, group software reset and interrupt summary registers
// Overview of operation
// (RL1) source codes 0-3 pick channel 1-4 recovered clock; flag gives e1 or t1 rate
// (RL2) source code 8 synthesises reference from master clock and drives reference pin out
// (RL3) source code 9 takes reference pin as input; outside supplies flagged rate
// (RL4) rx system clock source bit picks per-channel pins or backplane clock for all
// (RL5) tx system clock source bit picks per-channel pins or backplane clock for all
// (RL6) tx line clock source bit picks per-channel pins or reference pin for all
// (RL7) four-bit clock-out select sets clock-out frequency from master clock table
// (RL8) writing a reset bit from zero to one resets its function group
// (RL9) group reset stays applied until host writes zero to its bit
// (RL10) bit 3 hdlc big, bit 2 line interface, bit 1 bit tester, bit 0 framer
// (RL11) small hdlc controllers follow the framer reset bit
// (RL12) identification reads device code in top five bits, revision in low three
// (RL13) revision starts at zero and counts up per die revision, bit 0 lsb
// (RL14) framer summary bits 3-0 show live interrupt of framers 4-1
// (RL15) bit tester summary bits 3-0 show live interrupt of testers 4-1
// (RL16) source select and frequency flag choose the backplane clock reference
// (RL17) software sets frequency flag to match mode of chosen recovered channel
// (RL18) unused bits read zero and ignore writes; reserved source codes hold prior source
// (RL19) summary bits are read-only mirrors that clear when the source clears
`timescale 1ns/1ns
`default_nettype none
module global_clock_reset_status_bank
   import clock_bank_pkg::*;
#(
   parameter logic [4:0] device_code   = 5'h05, // arbitrary value
   parameter logic [2:0] revision_code = 3'h0
)
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic [3:0]  rx_recovered_clock,
   input  wire logic        ref_clock_pin_i,
   output logic             ref_clock_pin_o,
   output logic             ref_clock_pin_oe,
   output logic             backplane_clock_out,
   output logic             bp_ref_freq_flag,
   input  wire logic [3:0]  rx_sys_clock_pin,
   input  wire logic [3:0]  tx_sys_clock_pin,
   input  wire logic [3:0]  tx_line_clock_pin,
   output logic [3:0]       rx_sys_clock,
   output logic [3:0]       tx_sys_clock,
   output logic [3:0]       tx_line_clock,
   output logic             clock_out_pin,
   output logic             hdlc_big_group_reset,
   output logic             hdlc_small_group_reset,
   output logic             line_if_group_reset,
   output logic             bit_tester_group_reset,
   output logic             framer_group_reset,
   input  wire logic [3:0]  framer_irq_flag,
   input  wire logic [3:0]  bit_tester_irq_flag
);

   // ==========================================================
   // bus slave: address phase capture, write in data phase
   bus_req_t       req;
   bus_req_t       next_req;
   logic           req_valid;
   logic           next_req_valid;
   bp_reference_t  bp_ref;
   bp_reference_t  next_bp_ref;
   clock_routing_t routing;
   clock_routing_t next_routing;
   group_reset_t   grp_reset;
   group_reset_t   next_grp_reset;
   logic [31:0]    next_hrdata;
   logic [3:0]     framer_summary;
   logic [3:0]     tester_summary;
   logic           addr_take;

   assign addr_take = hsel && hready && (htrans == htrans_nonseq || htrans == htrans_seq);

   always_comb
   begin
      next_req_valid = addr_take;
      next_req.write = hwrite;
      next_req.index = haddr[9:2];
      if (haddr[31:10] != 22'h000000 || haddr[1:0] != 2'h0)
      begin
         next_req.index = 8'h00;
      end
      next_bp_ref    = bp_ref;
      next_routing   = routing;
      next_grp_reset = grp_reset;
      if (req_valid && req.write)
      begin
         unique case (req.index)
            idx_bp_reference:  next_bp_ref    = {hwdata[7:3], 3'h0}; // RL16 RL18
            idx_clock_routing: next_routing   = {1'h0, hwdata[6:0]}; // RL18
            idx_group_reset:   next_grp_reset = {4'h0, hwdata[3:0]}; // RL8 RL9 RL18
            default:           next_bp_ref    = bp_ref;
         endcase
      end
      // reads see the value of a write finishing in this same cycle
      next_hrdata = rdata_reset;
      if (addr_take && !hwrite)
      begin
         unique case (next_req.index)
            idx_bp_reference:  next_hrdata[7:0] = next_bp_ref;
            idx_clock_routing: next_hrdata[7:0] = next_routing;
            idx_group_reset:   next_hrdata[7:0] = next_grp_reset;
            idx_device_ident:  next_hrdata[7:0] = {device_code, revision_code}; // RL12 RL13
            idx_framer_irq:    next_hrdata[3:0] = framer_irq_flag; // RL14 RL19
            idx_tester_irq:    next_hrdata[3:0] = bit_tester_irq_flag; // RL15 RL19
            default:           next_hrdata = rdata_reset; // RL18
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         req_valid <= 1'h0;
         req       <= '0;
         bp_ref    <= bp_reference_reset;
         routing   <= clock_routing_reset;
         grp_reset <= group_reset_reset;
         hrdata    <= rdata_reset;
         hreadyout <= 1'h1;
         hresp     <= hresp_okay;
      end
      else
      begin
         req_valid <= next_req_valid;
         req       <= next_req;
         bp_ref    <= next_bp_ref;
         routing   <= next_routing;
         grp_reset <= next_grp_reset;
         hrdata    <= next_hrdata;
         hreadyout <= 1'h1;
         hresp     <= hresp_okay;
      end
   end

   // ==========================================================
   // group software resets: level while the bit holds one
   always_comb
   begin
      framer_summary = framer_irq_flag;
      tester_summary = bit_tester_irq_flag;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hdlc_big_group_reset   <= 1'h0;
         hdlc_small_group_reset <= 1'h0;
         line_if_group_reset    <= 1'h0;
         bit_tester_group_reset <= 1'h0;
         framer_group_reset     <= 1'h0;
      end
      else
      begin
         hdlc_big_group_reset   <= next_grp_reset.hdlc_big_group_reset; // RL10 RL8 RL9
         line_if_group_reset    <= next_grp_reset.line_if_group_reset; // RL10
         bit_tester_group_reset <= next_grp_reset.bit_tester_group_reset; // RL10
         framer_group_reset     <= next_grp_reset.framer_group_reset; // RL10
         hdlc_small_group_reset <= next_grp_reset.framer_group_reset; // RL11
      end
   end

   // ==========================================================
   // clock synthesis from the master clock
   logic        ref_nco_clock;
   logic [31:0] ref_step;
   logic [31:0] clock_out_pin_step;
   logic        clock_out_pin_level;

   always_comb
   begin
      ref_step  = bp_ref.bp_ref_freq_flag ? nco_step(t1_ref_khz) : nco_step(e1_ref_khz); // RL2
      clock_out_pin_step = nco_step(clock_out_khz[routing.clock_out_freq_sel]); // RL7
   end

   nco_clock_gen u_ref_nco (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .step        (ref_step),
      .clock_level (ref_nco_clock)
   );

   nco_clock_gen u_clock_out_pin_nco (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .step        (clock_out_pin_step),
      .clock_level (clock_out_pin_level)
   );

   // ==========================================================
   // backplane reference and channel clock routing
   // reserved source codes leave the last legal source in charge
   logic [3:0] active_source;
   logic [3:0] next_active_source;
   logic       next_backplane;
   logic       ref_pin_level;

   always_comb
   begin
      next_active_source = active_source;
      if (bp_ref.bp_ref_source_sel <= src_rx_ch4 || bp_ref.bp_ref_source_sel == src_master
          || bp_ref.bp_ref_source_sel == src_ext_pin)
      begin
         next_active_source = bp_ref.bp_ref_source_sel; // RL18
      end
      unique case (active_source)
         src_master:  next_backplane = ref_nco_clock; // RL2 RL16
         src_ext_pin: next_backplane = ref_clock_pin_i; // RL3 RL16
         default:     next_backplane = rx_recovered_clock[active_source[1:0]]; // RL1
      endcase
      ref_pin_level = ref_clock_pin_oe ? ref_clock_pin_o : ref_clock_pin_i;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         active_source       <= src_rx_ch1;
         backplane_clock_out <= 1'h0;
         bp_ref_freq_flag    <= 1'h0;
         ref_clock_pin_o     <= 1'h0;
         ref_clock_pin_oe    <= 1'h0;
         rx_sys_clock        <= 4'h0;
         tx_sys_clock        <= 4'h0;
         tx_line_clock       <= 4'h0;
         clock_out_pin       <= 1'h0;
      end
      else
      begin
         active_source       <= next_active_source;
         backplane_clock_out <= next_backplane;
         bp_ref_freq_flag    <= bp_ref.bp_ref_freq_flag; // RL1 RL3
         ref_clock_pin_o     <= ref_nco_clock; // RL2
         ref_clock_pin_oe    <= (active_source == src_master); // RL2 RL3
         rx_sys_clock        <= routing.rx_sys_clock_source ?
                                {4{backplane_clock_out}} : rx_sys_clock_pin; // RL4
         tx_sys_clock        <= routing.tx_sys_clock_source ?
                                {4{backplane_clock_out}} : tx_sys_clock_pin; // RL5
         tx_line_clock       <= routing.tx_line_clock_source ?
                                {4{ref_pin_level}} : tx_line_clock_pin; // RL6
         clock_out_pin       <= clock_out_pin_level; // RL7
      end
   end

   // ==========================================================
   // checks
   a_rx_ref_route: assert property (@(posedge hclk) disable iff (!hresetn) // RL1
      active_source <= src_rx_ch4
      |=> backplane_clock_out == $past(rx_recovered_clock[active_source[1:0]]))
      else $error("backplane clock not following recovered clock");

   a_master_ref_drive: assert property (@(posedge hclk) disable iff (!hresetn) // RL2
      (active_source == src_master) ##1 (active_source == src_master)
      |-> ref_clock_pin_oe && backplane_clock_out == $past(ref_nco_clock))
      else $error("master derived reference not driven");

   a_ext_ref_input: assert property (@(posedge hclk) disable iff (!hresetn) // RL3
      (active_source == src_ext_pin) |=> !ref_clock_pin_oe
      && backplane_clock_out == $past(ref_clock_pin_i))
      else $error("external reference pin not used as input");

   a_rx_sys_route: assert property (@(posedge hclk) disable iff (!hresetn) // RL4
      routing.rx_sys_clock_source |=> rx_sys_clock == {4{$past(backplane_clock_out)}})
      else $error("rx system clock not from backplane");

   a_tx_sys_route: assert property (@(posedge hclk) disable iff (!hresetn) // RL5
      !routing.tx_sys_clock_source |=> tx_sys_clock == $past(tx_sys_clock_pin))
      else $error("tx system clock not from pins");

   a_tx_line_route: assert property (@(posedge hclk) disable iff (!hresetn) // RL6
      routing.tx_line_clock_source && !ref_clock_pin_oe
      |=> tx_line_clock == {4{$past(ref_clock_pin_i)}})
      else $error("tx line clock not from reference pin");

   a_reset_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RL9
      framer_group_reset && !(req_valid && req.write && req.index == idx_group_reset)
      |=> framer_group_reset)
      else $error("framer reset dropped without a write");

   a_small_hdlc_reset: assert property (@(posedge hclk) disable iff (!hresetn) // RL11
      hdlc_small_group_reset == grp_reset.framer_group_reset
      && framer_group_reset == grp_reset.framer_group_reset)
      else $error("small hdlc reset differs from framer reset");

   a_ident_read: assert property (@(posedge hclk) disable iff (!hresetn) // RL12
      addr_take && !hwrite && haddr == {22'h000000, idx_device_ident, 2'h0}
      |=> hrdata == {24'h000000, device_code, revision_code})
      else $error("identification read wrong");

   a_framer_summary: assert property (@(posedge hclk) disable iff (!hresetn) // RL14
      addr_take && !hwrite && haddr == {22'h000000, idx_framer_irq, 2'h0}
      |=> hrdata == {28'h0000000, $past(framer_summary)})
      else $error("framer summary read wrong");

   a_tester_summary: assert property (@(posedge hclk) disable iff (!hresetn) // RL15
      addr_take && !hwrite && haddr == {22'h000000, idx_tester_irq, 2'h0}
      |=> hrdata == {28'h0000000, $past(tester_summary)})
      else $error("bit tester summary read wrong");

   a_reserved_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RL18
      bp_ref.bp_ref_source_sel > src_ext_pin |=> $stable(active_source))
      else $error("reserved source code changed the source");

endmodule // global_clock_reset_status_bank
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking testbench for the global clock, reset and status bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import clock_bank_pkg::*;

   // ==========================================================
   // signals
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd_s;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        rdy_s, rsp_s, ref_drive, ref_wire, ref_o, ref_oe, bp_clk, bp_flag, clk_out;
   logic [3:0]  rx_rec, rx_pin, tx_pin, tl_pin, rx_clk, tx_clk, tl_clk, f_irq, b_irq;
   logic        r_big, r_small, r_line, r_bert, r_frm;
   int          mismatches, num_checks, seed;
   localparam logic [4:0] dev_code = 5'h0A; // arbitrary value
   localparam logic [2:0] rev_code = 3'h2;

   // the wire level of the two-way reference pin, seen by the design too
   assign ref_wire = ref_oe ? ref_o : ref_drive;
   assign hready   = hreadyout;

   global_clock_reset_status_bank #(.device_code(dev_code), .revision_code(rev_code)) dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_recovered_clock(rx_rec),
      .ref_clock_pin_i(ref_wire), .ref_clock_pin_o(ref_o), .ref_clock_pin_oe(ref_oe),
      .backplane_clock_out(bp_clk), .bp_ref_freq_flag(bp_flag), .rx_sys_clock_pin(rx_pin),
      .tx_sys_clock_pin(tx_pin), .tx_line_clock_pin(tl_pin), .rx_sys_clock(rx_clk),
      .tx_sys_clock(tx_clk), .tx_line_clock(tl_clk), .clock_out_pin(clk_out),
      .hdlc_big_group_reset(r_big), .hdlc_small_group_reset(r_small),
      .line_if_group_reset(r_line), .bit_tester_group_reset(r_bert),
      .framer_group_reset(r_frm), .framer_irq_flag(f_irq), .bit_tester_irq_flag(b_irq));

   // ==========================================================
   // clock, sampling and watchdog
   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // mid-cycle samples avoid racing the design's own edge updates
   always @(negedge hclk)
   begin
      rd_s  <= hrdata;
      rdy_s <= hreadyout;
      rsp_s <= hresp;
   end

   // the whole sequence needs about 85000 cycles; stay under 95000
   initial
   begin
      #950000;
      mismatches++;
      summarize();
   end

   // ==========================================================
   // tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= addr;
      hwrite <= wr;
      htrans <= htrans_nonseq;
      // only the watchdog ends a wait for ready
      @(posedge hclk);
      while (rdy_s !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= wd;
      @(posedge hclk);
      while (rdy_s !== 1'b1) @(posedge hclk);
      rd = rd_s;
   endtask

   function automatic logic [31:0] adr(input logic [7:0] idx);
      return {22'h0, idx, 2'b00};
   endfunction

   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      logic [31:0] d;
      bus(1'b1, adr(idx), {24'h0, v}, d);
   endtask

   task automatic rd_chk(input logic [31:0] addr, input logic [7:0] exp);
      logic [31:0] d;
      bus(1'b0, addr, 32'h0, d);
      check(d, {24'h0, exp});
      check(32'(rsp_s), 32'(hresp_okay));
   endtask

   task automatic settle(input int n);
      repeat (n) @(negedge hclk);
   endtask

   // counts rising edges of one clock output over a span of cycles
   task automatic rises(input int sel, input int cycles, output int n);
      logic prev, cur;
      n = 0;
      // start from the level already present so no false edge is counted
      prev = (sel == 0) ? ref_o : (sel == 1) ? clk_out : bp_clk;
      repeat (cycles)
      begin
         @(negedge hclk);
         cur = (sel == 0) ? ref_o : (sel == 1) ? clk_out : bp_clk;
         if (cur === 1'b1 && prev === 1'b0)
            n++;
         prev = cur;
      end
   endtask

   task automatic freq_chk(input int sel, input int khz, input int cycles);
      int n, e;
      rises(sel, cycles, n);
      e = (khz * cycles) / int'(hclk_khz);
      check({31'h0, (n >= e - 1 && n <= e + 1)}, 32'h1);
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      logic [7:0]  v, r;
      logic        b;
      logic [31:0] d;
      seed = 98;
      hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = 32'h0; ref_drive = 1'b0; rx_rec = 4'h0;
      rx_pin = 4'h0; tx_pin = 4'h0; tl_pin = 4'h0; f_irq = 4'h0; b_irq = 4'h0;
      mismatches = 0; num_checks = 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      // reset values and identity
      rd_chk(adr(idx_clock_routing), 8'h00);
      rd_chk(adr(idx_group_reset), 8'h00);
      rd_chk(adr(idx_framer_irq), 8'h00);
      rd_chk(adr(idx_device_ident), {dev_code, rev_code});
      wr(idx_device_ident, 8'h00);
      rd_chk(adr(idx_device_ident), {dev_code, rev_code});
      // unmapped and aliased places
      wr(8'hF5, 8'hFF);
      rd_chk(adr(8'hF5), 8'h00);
      wr(idx_clock_routing, 8'h0F);
      bus(1'b1, adr(idx_clock_routing) | 32'h1000, 32'h30, d);
      rd_chk(adr(idx_clock_routing) | 32'h1000, 8'h00);
      rd_chk(adr(idx_clock_routing), 8'h0F);
      // group software resets, with corner values first
      for (int i = 0; i < 8; i++)
      begin
         v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
         wr(idx_group_reset, v);
         settle(2);
         check(32'({r_big, r_line, r_bert, r_frm}), 32'(v[3:0]));
         check(32'(r_small), 32'(v[0]));
         rd_chk(adr(idx_group_reset), v & 8'h0F);
      end
      // live interrupt summaries
      for (int i = 0; i < 6; i++)
      begin
         @(posedge hclk);
         f_irq <= (i == 5) ? 4'h0 : 4'($random(seed));
         b_irq <= (i == 5) ? 4'h0 : 4'($random(seed));
         settle(2);
         rd_chk(adr(idx_framer_irq), {4'h0, f_irq});
         rd_chk(adr(idx_tester_irq), {4'h0, b_irq});
      end
      // recovered clock sources, spare bits written high read zero
      for (int ch = 0; ch < 4; ch++)
      begin
         b = 1'($random(seed));
         wr(idx_bp_reference, {4'(ch), b, 3'h7});
         rd_chk(adr(idx_bp_reference), {4'(ch), b, 3'h0});
         @(posedge hclk);
         rx_rec <= 4'h1 << ch;
         settle(4);
         check(32'(bp_clk), 32'h1);
         check(32'(bp_flag), 32'(b));
         check(32'(ref_oe), 32'h0);
         @(posedge hclk);
         rx_rec <= ~(4'h1 << ch);
         settle(4);
         check(32'(bp_clk), 32'h0);
      end
      // a reserved code keeps the channel 4 source
      wr(idx_bp_reference, 8'h50);
      rd_chk(adr(idx_bp_reference), 8'h50);
      @(posedge hclk);
      rx_rec <= 4'h8;
      settle(4);
      check(32'(bp_clk), 32'h1);
      // external pin reference and clock routing
      wr(idx_bp_reference, {src_ext_pin, 4'h0});
      for (int i = 0; i < 8; i++)
      begin
         r = 8'($random(seed));
         b = 1'($random(seed));
         wr(idx_clock_routing, r);
         @(posedge hclk);
         ref_drive <= b;
         rx_pin <= 4'($random(seed));
         tx_pin <= 4'($random(seed));
         tl_pin <= 4'($random(seed));
         rx_rec <= 4'($random(seed));
         settle(5);
         check(32'(ref_oe), 32'h0);
         check(32'(bp_clk), 32'(b));
         check(32'(rx_clk), 32'(r[6] ? {4{b}} : rx_pin));
         check(32'(tx_clk), 32'(r[5] ? {4{b}} : tx_pin));
         check(32'(tl_clk), 32'(r[4] ? {4{b}} : tl_pin));
         rd_chk(adr(idx_clock_routing), r & 8'h7F);
      end
      // reference synthesised from the master clock at either rate
      for (int f = 0; f < 2; f++)
      begin
         wr(idx_bp_reference, {src_master, 1'(f), 3'h0});
         settle(4);
         check(32'(ref_oe), 32'h1);
         freq_chk(0, f ? t1_ref_khz : e1_ref_khz, 5000);
         freq_chk(2, f ? t1_ref_khz : e1_ref_khz, 5000);
      end
      // every clock-out code
      for (int c = 0; c < 16; c++)
      begin
         wr(idx_clock_routing, 8'(c));
         settle(8);
         freq_chk(1, clock_out_khz[c], 4000);
      end
      summarize();
   end

endmodule // testbench
`default_nettype wire
